// *** rtl/fsd_regs.svh ***
`ifndef FSD_REGS_SVH
`define FSD_REGS_SVH

// Flag status reset value: controller ready, all else clear
`define FSD_FLAG_RST  8'h80

// Flag status field positions
`define FSD_FB_READY  7
`define FSD_FB_ESUSP  6
`define FSD_FB_EERR   5
`define FSD_FB_PERR   4
`define FSD_FB_VPP    3
`define FSD_FB_PSUSP  2
`define FSD_FB_PROT   1
`define FSD_FB_RSVD   0

// Identification answer length in bytes
`define FSD_ID_LEN    2'h3

// Output enables (active low) per protocol while answering
`define FSD_OE_EXT    4'hD
`define FSD_OE_DUAL   4'hC
`define FSD_OE_QUAD   4'h0
`define FSD_OE_OFF    4'hF

`endif

// *** rtl/fsd_pkg.sv ***
`default_nettype none

package fsd_pkg;

  // Code value equals the number of data lanes in use
  typedef enum logic [2:0] {
    PR_EXT  = 3'h1,
    PR_DUAL = 3'h2,
    PR_QUAD = 3'h4
  } fsd_proto_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_OPC  = 5'b00010,
    ST_RESP = 5'b00100,
    ST_PASS = 5'b01000,
    ST_IGN  = 5'b10000
  } fsd_state_t;

  typedef enum logic [7:0] {
    OP_RSTEN  = 8'h66, OP_RSTMEM = 8'h99, OP_RDID_A = 8'h9E,
    OP_RDID_B = 8'h9F, OP_MIO_ID = 8'hAF, OP_RDDISC = 8'h5A,
    OP_READ   = 8'h03, OP_FREAD  = 8'h0B, OP_DOFR   = 8'h3B,
    OP_DIOFR  = 8'hBB, OP_QOFR   = 8'h6B, OP_QIOFR  = 8'hEB,
    OP_WREN   = 8'h06, OP_WRDI   = 8'h04, OP_RDSR   = 8'h05,
    OP_WRSR   = 8'h01, OP_RDLR   = 8'hE8, OP_WRLR   = 8'hE5,
    OP_RD_FLG = 8'h70, OP_CL_FLG = 8'h50, OP_RDNVCR = 8'hB5,
    OP_WRNVCR = 8'hB1, OP_RDVCR  = 8'h85, OP_WRVCR  = 8'h81,
    OP_RDEVCR = 8'h65, OP_WREVCR = 8'h61, OP_PP     = 8'h02,
    OP_DIFP   = 8'hA2, OP_DIEFP  = 8'hD2, OP_QIFP   = 8'h32,
    OP_QIEFP  = 8'h12, OP_SSE    = 8'h20, OP_SE     = 8'hD8,
    OP_BE     = 8'hC7, OP_RESUME = 8'h7A, OP_SUSP   = 8'h75,
    OP_RDOTP  = 8'h4B, OP_PGOTP  = 8'h42, OP_DPD    = 8'hB9,
    OP_RELDPD = 8'hAB
  } fsd_op_t;

endpackage : fsd_pkg

`default_nettype wire

// *** rtl/fsd_link.sv ***
`default_nettype none

module fsd_link (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] dq,
  // Lanes in use, 1, 2 or 4
  input  wire logic [2:0] lanes,
  // Framing and bytes
  output logic            sck_fall,
  output logic            frame_on,
  output logic            byte_vld,
  output logic      [7:0] byte_dat
);

  logic       sck_m_r, sck_s_r, sck_d_r;
  logic       cs_m_r, cs_s_r;
  logic [3:0] dq_m_r, dq_s_r;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] bcnt_r;
  logic [3:0] bcnt_sum;
  logic       vld_r;
  logic [7:0] dat_r;
  wire        sck_rise;
  wire        done;

  ////////////////////////////////////////////////////////////////////////
  // Pins pass two flops; data and clock share the same delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      cs_m_r  <= 1'b1;
      cs_s_r  <= 1'b1;
      dq_m_r  <= 4'h0;
      dq_s_r  <= 4'h0;
    end else begin
      sck_m_r <= sck;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      cs_m_r  <= cs_n;
      cs_s_r  <= cs_m_r;
      dq_m_r  <= dq;
      dq_s_r  <= dq_m_r;
    end
  end

  assign sck_rise = sck_s_r & ~sck_d_r;
  assign sck_fall = ~sck_s_r & sck_d_r;
  assign frame_on = ~cs_s_r;

  ////////////////////////////////////////////////////////////////////////
  // Input shifter, MSB first, lanes wide per edge
  assign sh_nxt = (lanes == 3'h4) ? {sh_r[3:0], dq_s_r[3:0]} :
                  (lanes == 3'h2) ? {sh_r[5:0], dq_s_r[1:0]} :
                                    {sh_r[6:0], dq_s_r[0]};
  assign bcnt_sum = bcnt_r + {1'b0, lanes};
  assign done     = sck_rise & (bcnt_sum == 4'h8);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r   <= 8'h00;
      bcnt_r <= 4'h0;
    end else if (!frame_on) begin
      bcnt_r <= 4'h0;
    end else if (sck_rise) begin
      sh_r   <= sh_nxt;
      bcnt_r <= done ? 4'h0 : bcnt_sum;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_r <= 1'b0;
      dat_r <= 8'h00;
    end else begin
      vld_r <= done & frame_on;
      if (done) begin
        dat_r <= sh_nxt;
      end
    end
  end

  assign byte_vld = vld_r;
  assign byte_dat = dat_r;

endmodule // fsd_link

`default_nettype wire

// *** rtl/fsd_flag_decode.sv ***
`include "fsd_regs.svh"
`default_nettype none

// Overview of operation
// - Bit 7 low while controller busy
// - Busy reflects only program, erase, register writes
// - Bit 6 shows erase suspended or pending
// - Bit 2 shows program suspended or pending
// - Bit 5 sets on erase failure
// - Bit 4 sets on program failure
// - Bit 3 sets on bad supply voltage
// - Bit 1 sets on protected target access
// - Opcode 70h returns volatile flags, all protocols
// - Status bits follow hardware, no command needed
// - Error bits stay until opcode 50h
// - Array or register write with pending error flags protection
// - AFh dual/quad only; 9Eh/9Fh extended only
// - 3Bh accepted extended and dual only
// - Dual protocol enters dual read by three codes
// - 6Bh accepted extended and quad only
// - Quad protocol enters quad read by three codes
// - Register commands have no address or dummy
// - Opcode lanes: one, two or four

module fsd_flag_decode #(
  // Arbitrary identification bytes, first byte sent first
  parameter logic [23:0] ID_BYTES = 24'h5AC33C
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // Serial link
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic [3:0] DQ_I,
  output logic      [3:0] DQ_O,
  output logic      [3:0] DQ_OE_N,
  // Protocol select
  input  wire logic       PROTO_DUAL,
  input  wire logic       PROTO_QUAD,
  // Controller state
  input  wire logic       PEC_BUSY,
  input  wire logic       ERS_SUSP,
  input  wire logic       PGM_SUSP,
  // Error events
  input  wire logic       ERS_FAIL,
  input  wire logic       PGM_FAIL,
  input  wire logic       PGM_ONE_FAIL,
  input  wire logic       VPP_FAIL,
  input  wire logic       PROT_FAIL,
  // Decoded command
  output logic            CMD_STB,
  output logic            CMD_REJ,
  output logic      [7:0] CMD_CODE,
  // Flag status
  output logic      [7:0] FLAG_STATUS
);

  logic                 rst_m_r;
  logic                 rst_n;
  fsd_pkg::fsd_proto_t  proto_r;
  fsd_pkg::fsd_proto_t  proto_sel;
  fsd_pkg::fsd_state_t  state_r;
  fsd_pkg::fsd_state_t  state_nxt;
  logic           [7:0] flag_r;
  logic           [7:0] flag_nxt;
  logic                 stb_r;
  logic                 rej_r;
  logic           [7:0] code_r;
  logic           [7:0] out_sh_r;
  logic           [7:0] out_sh_nxt;
  logic           [3:0] ocnt_r;
  logic           [3:0] ocnt_nxt;
  logic           [1:0] idx_r;
  logic           [1:0] idx_nxt;
  logic                 first_r;
  logic                 first_nxt;
  logic                 fsr_r;
  logic                 fsr_nxt;
  logic                 sck_fall;
  logic                 frame_on;
  logic                 byte_vld;
  logic           [7:0] opc;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_m_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n   <= rst_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link front end
  fsd_link u_link (
    .clk      (CLK),
    .rst_n    (rst_n),
    .sck      (SCK),
    .cs_n     (CS_N),
    .dq       (DQ_I),
    .lanes    (proto_r),
    .sck_fall (sck_fall),
    .frame_on (frame_on),
    .byte_vld (byte_vld),
    .byte_dat (opc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Opcode acceptance per protocol
  wire in_all = opc inside {
    fsd_pkg::OP_RSTEN,  fsd_pkg::OP_RSTMEM, fsd_pkg::OP_RDDISC,
    fsd_pkg::OP_FREAD,  fsd_pkg::OP_WREN,   fsd_pkg::OP_WRDI,
    fsd_pkg::OP_RDSR,   fsd_pkg::OP_WRSR,   fsd_pkg::OP_RDLR,
    fsd_pkg::OP_WRLR,   fsd_pkg::OP_RD_FLG, fsd_pkg::OP_CL_FLG,
    fsd_pkg::OP_RDNVCR, fsd_pkg::OP_WRNVCR, fsd_pkg::OP_RDVCR,
    fsd_pkg::OP_WRVCR,  fsd_pkg::OP_RDEVCR, fsd_pkg::OP_WREVCR,
    fsd_pkg::OP_PP,     fsd_pkg::OP_SSE,    fsd_pkg::OP_SE,
    fsd_pkg::OP_BE,     fsd_pkg::OP_RESUME, fsd_pkg::OP_SUSP,
    fsd_pkg::OP_RDOTP,  fsd_pkg::OP_PGOTP,  fsd_pkg::OP_DPD,
    fsd_pkg::OP_RELDPD};
  wire in_ext = opc inside {
    fsd_pkg::OP_RDID_A, fsd_pkg::OP_RDID_B, fsd_pkg::OP_READ};
  wire in_mio = (opc == fsd_pkg::OP_MIO_ID);
  wire in_ed  = opc inside {
    fsd_pkg::OP_DOFR, fsd_pkg::OP_DIOFR,
    fsd_pkg::OP_DIFP, fsd_pkg::OP_DIEFP};
  wire in_eq  = opc inside {
    fsd_pkg::OP_QOFR, fsd_pkg::OP_QIOFR,
    fsd_pkg::OP_QIFP, fsd_pkg::OP_QIEFP};
  wire ok_ext  = in_all | in_ext | in_ed | in_eq;
  wire ok_dual = in_all | in_mio | in_ed;
  wire ok_quad = in_all | in_mio | in_eq;
  wire acc = (proto_r == fsd_pkg::PR_EXT)  ? ok_ext  :
             (proto_r == fsd_pkg::PR_DUAL) ? ok_dual : ok_quad;

  // Commands that change array or registers
  wire is_mod = opc inside {
    fsd_pkg::OP_WRSR,   fsd_pkg::OP_WRLR,   fsd_pkg::OP_WRNVCR,
    fsd_pkg::OP_WRVCR,  fsd_pkg::OP_WREVCR, fsd_pkg::OP_PP,
    fsd_pkg::OP_DIFP,   fsd_pkg::OP_DIEFP,  fsd_pkg::OP_QIFP,
    fsd_pkg::OP_QIEFP,  fsd_pkg::OP_SSE,    fsd_pkg::OP_SE,
    fsd_pkg::OP_BE,     fsd_pkg::OP_PGOTP};
  wire is_fsr = (opc == fsd_pkg::OP_RD_FLG);
  wire is_clr = (opc == fsd_pkg::OP_CL_FLG);
  wire is_id  = in_ext & (opc != fsd_pkg::OP_READ) | in_mio;

  wire cmd_go  = (state_r == fsd_pkg::ST_OPC) & byte_vld;
  wire cmd_acc = cmd_go & acc;
  wire cmd_rej = cmd_go & ~acc;
  wire clr_stb = cmd_acc & is_clr;
  wire rsp_go  = cmd_acc & (is_fsr | is_id);

  ////////////////////////////////////////////////////////////////////////
  // Protocol is frozen for the whole frame so lane count cannot shift
  assign proto_sel = PROTO_QUAD ? fsd_pkg::PR_QUAD :
                     PROTO_DUAL ? fsd_pkg::PR_DUAL : fsd_pkg::PR_EXT;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      proto_r <= fsd_pkg::PR_EXT;
    end else if (state_r == fsd_pkg::ST_IDLE) begin
      proto_r <= proto_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fsd_pkg::ST_IDLE: begin
        if (frame_on) begin
          state_nxt = fsd_pkg::ST_OPC;
        end
      end
      fsd_pkg::ST_OPC: begin
        if (rsp_go) begin
          state_nxt = fsd_pkg::ST_RESP;
        end else if (cmd_acc) begin
          state_nxt = fsd_pkg::ST_PASS;
        end else if (cmd_rej) begin
          state_nxt = fsd_pkg::ST_IGN;
        end
      end
      fsd_pkg::ST_RESP,
      fsd_pkg::ST_PASS,
      fsd_pkg::ST_IGN: begin
        state_nxt = state_r;
      end
      default: begin
        state_nxt = fsd_pkg::ST_IDLE;
      end
    endcase
    if (!frame_on) begin
      state_nxt = fsd_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= fsd_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag status; hardware set wins over the clear command
  wire err_pend = flag_r[`FSD_FB_EERR] | flag_r[`FSD_FB_PERR] |
                  flag_r[`FSD_FB_VPP]  | flag_r[`FSD_FB_PROT];
  wire prot_evt = PROT_FAIL | (cmd_acc & is_mod & err_pend);

  always_comb begin
    flag_nxt = flag_r;
    flag_nxt[`FSD_FB_READY] = ~PEC_BUSY;
    flag_nxt[`FSD_FB_ESUSP] = ERS_SUSP;
    flag_nxt[`FSD_FB_PSUSP] = PGM_SUSP;
    flag_nxt[`FSD_FB_EERR]  = ERS_FAIL |
                              (flag_r[`FSD_FB_EERR] & ~clr_stb);
    flag_nxt[`FSD_FB_PERR]  = PGM_FAIL | PGM_ONE_FAIL |
                              (flag_r[`FSD_FB_PERR] & ~clr_stb);
    flag_nxt[`FSD_FB_VPP]   = VPP_FAIL |
                              (flag_r[`FSD_FB_VPP] & ~clr_stb);
    flag_nxt[`FSD_FB_PROT]  = prot_evt |
                              (flag_r[`FSD_FB_PROT] & ~clr_stb);
    flag_nxt[`FSD_FB_RSVD]  = 1'b0;
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= `FSD_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign FLAG_STATUS = flag_r;

  ////////////////////////////////////////////////////////////////////////
  // Decoded command strobes for the rest of the device
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      stb_r  <= 1'b0;
      rej_r  <= 1'b0;
      code_r <= 8'h00;
    end else begin
      stb_r <= cmd_acc;
      rej_r <= cmd_rej;
      if (cmd_go) begin
        code_r <= opc;
      end
    end
  end

  assign CMD_STB  = stb_r;
  assign CMD_REJ  = rej_r;
  assign CMD_CODE = code_r;

  ////////////////////////////////////////////////////////////////////////
  // Answer shifter; the flag byte is resampled at every byte boundary
  wire [7:0] id_sel = (idx_r == 2'h0) ? ID_BYTES[23:16] :
                      (idx_r == 2'h1) ? ID_BYTES[15:8]  :
                      (idx_r == 2'h2) ? ID_BYTES[7:0]   : 8'h00;
  wire [7:0] rsp_byte = fsr_r ? flag_r : id_sel;
  wire [3:0] ocnt_sum = ocnt_r + {1'b0, proto_r};
  wire [7:0] sh_left  = (proto_r == fsd_pkg::PR_QUAD) ?
                          {out_sh_r[3:0], 4'h0} :
                        (proto_r == fsd_pkg::PR_DUAL) ?
                          {out_sh_r[5:0], 2'h0} :
                          {out_sh_r[6:0], 1'b0};
  wire       in_resp  = (state_r == fsd_pkg::ST_RESP);

  always_comb begin
    out_sh_nxt = out_sh_r;
    ocnt_nxt   = ocnt_r;
    idx_nxt    = idx_r;
    first_nxt  = first_r;
    fsr_nxt    = fsr_r;
    if (rsp_go) begin
      fsr_nxt    = is_fsr;
      out_sh_nxt = is_fsr ? flag_r : ID_BYTES[23:16];
      idx_nxt    = 2'h1;
      ocnt_nxt   = 4'h0;
      first_nxt  = 1'b1;
    end else if (in_resp & sck_fall) begin
      if (first_r) begin
        first_nxt = 1'b0;
      end else if (ocnt_sum == 4'h8) begin
        out_sh_nxt = rsp_byte;
        ocnt_nxt   = 4'h0;
        if (idx_r != `FSD_ID_LEN) begin
          idx_nxt = idx_r + 2'h1;
        end
      end else begin
        out_sh_nxt = sh_left;
        ocnt_nxt   = ocnt_sum;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_r <= 8'h00;
      ocnt_r   <= 4'h0;
      idx_r    <= 2'h0;
      first_r  <= 1'b0;
      fsr_r    <= 1'b0;
    end else begin
      out_sh_r <= out_sh_nxt;
      ocnt_r   <= ocnt_nxt;
      idx_r    <= idx_nxt;
      first_r  <= first_nxt;
      fsr_r    <= fsr_nxt;
    end
  end

  // Extended answers on line 1, dual on 1:0, quad on 3:0
  assign DQ_O = (proto_r == fsd_pkg::PR_QUAD) ? out_sh_r[7:4] :
                (proto_r == fsd_pkg::PR_DUAL) ? {2'h0, out_sh_r[7:6]} :
                                                {2'h0, out_sh_r[7], 1'b0};
  assign DQ_OE_N = !in_resp ? `FSD_OE_OFF :
                   (proto_r == fsd_pkg::PR_QUAD) ? `FSD_OE_QUAD :
                   (proto_r == fsd_pkg::PR_DUAL) ? `FSD_OE_DUAL :
                                                   `FSD_OE_EXT;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  busy_ready_a: assert property (
    ##1 FLAG_STATUS[7] == !$past(PEC_BUSY))
    else $error("ready bit does not follow busy");

  erase_susp_a: assert property (
    ERS_SUSP |=> FLAG_STATUS[6] ##1 (FLAG_STATUS[6] == $past(ERS_SUSP)))
    else $error("erase suspend bit wrong");

  prog_susp_a: assert property (
    !PGM_SUSP |=> !FLAG_STATUS[2])
    else $error("program suspend bit wrong");

  erase_err_a: assert property (
    ERS_FAIL |=> FLAG_STATUS[5])
    else $error("erase error not set");

  prog_err_a: assert property (
    (PGM_FAIL || PGM_ONE_FAIL) |=> FLAG_STATUS[4])
    else $error("program error not set");

  vpp_err_a: assert property (
    VPP_FAIL |=> FLAG_STATUS[3])
    else $error("supply error not set");

  prot_err_a: assert property (
    PROT_FAIL |=> FLAG_STATUS[1])
    else $error("protection error not set");

  err_hold_a: assert property (
    (FLAG_STATUS[5] && !clr_stb) |=> FLAG_STATUS[5])
    else $error("erase error dropped without clear");

  err_clear_a: assert property (
    (clr_stb && !VPP_FAIL) |=> !FLAG_STATUS[3])
    else $error("clear command left supply error");

  pend_prot_a: assert property (
    (cmd_acc && is_mod && err_pend) |=> FLAG_STATUS[1])
    else $error("pending error did not flag protection");

  rsvd_zero_a: assert property (
    FLAG_STATUS[0] == 1'b0)
    else $error("reserved bit nonzero");

  quad_dual_a: assert property (
    (cmd_go && proto_r == fsd_pkg::PR_QUAD && opc == 8'h3B)
      |=> CMD_REJ && !CMD_STB)
    else $error("dual read accepted in quad");

  reject_ign_a: assert property (
    cmd_rej |=> (state_r == fsd_pkg::ST_IGN) || !frame_on)
    else $error("rejected opcode not ignored");

  no_drive_a: assert property (
    (state_r != fsd_pkg::ST_RESP) |-> DQ_OE_N == 4'hF)
    else $error("pins driven outside an answer");

endmodule // fsd_flag_decode

`default_nettype wire

// *** verif/fsd_host.sv ***
`default_nettype none

module fsd_host (
  // Clock
  input  wire logic       clk,
  // Serial pins
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] dq,
  input  wire logic [3:0] dq_in,
  input  wire logic [3:0] oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] oe_min;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dq = 4'h0;
    oe_min = 4'hF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // 80 ns serial clock made of 4 + 4 system cycles
  task automatic half(input logic lvl);
    sck <= lvl;
    repeat (4) @(posedge clk);
  endtask

  // Unused lanes toggle so stale data cannot pass for a real bit
  task automatic xfer(input logic [7:0] op, input int ln, input int nbyt,
                      output logic [23:0] rd);
    logic [7:0] sh;
    logic [3:0] v;
    sh = op;
    rd = 24'h000000;
    oe_min = 4'hF;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < 8 / ln; i++) begin
      v = ~dq;
      for (int b = 0; b < ln; b++) v[b] = sh[8 - ln + b];
      dq <= v;
      sh = sh << ln;
      half(1'b0);
      half(1'b1);
    end
    for (int i = 0; i < nbyt * 8 / ln; i++) begin
      dq <= ~dq;
      half(1'b0);
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      for (int b = ln - 1; b >= 0; b--)
        rd = {rd[22:0], dq_in[(ln == 1) ? 1 : b]};
      oe_min = oe_min & oe_n;
      repeat (2) @(posedge clk);
    end
    cs_n <= 1'b1;
    sck <= 1'b0;
    dq <= ~dq;
    repeat (6) @(posedge clk);
  endtask
endmodule // fsd_host

`default_nettype wire

// *** verif/tb_top.sv ***
`include "fsd_regs.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [23:0] ID = 24'h5AC33C;

  logic       clk, resetn, sck, cs_n, proto_dual, proto_quad;
  logic [2:0] st;
  logic [4:0] ev;
  logic [3:0] h_dq, dq_w, dut_dq, dut_oe;
  logic       cmd_stb, cmd_rej;
  logic [7:0] cmd_code, flag;
  logic [23:0] rd;
  int         fail_count, compares, stb_n, rej_n;

  // Wire level: device lane where its enable is low, host otherwise
  assign dq_w = (dut_oe & h_dq) | (~dut_oe & dut_dq);

  fsd_flag_decode #(.ID_BYTES(ID)) dut_u (
    .CLK(clk), .RESETN(resetn), .SCK(sck), .CS_N(cs_n), .DQ_I(dq_w),
    .DQ_O(dut_dq), .DQ_OE_N(dut_oe), .PROTO_DUAL(proto_dual),
    .PROTO_QUAD(proto_quad), .PEC_BUSY(st[0]), .ERS_SUSP(st[1]),
    .PGM_SUSP(st[2]), .ERS_FAIL(ev[0]), .PGM_FAIL(ev[1]),
    .PGM_ONE_FAIL(ev[2]), .VPP_FAIL(ev[3]), .PROT_FAIL(ev[4]),
    .CMD_STB(cmd_stb), .CMD_REJ(cmd_rej), .CMD_CODE(cmd_code),
    .FLAG_STATUS(flag)
  );

  fsd_host host_u (
    .clk(clk), .sck(sck), .cs_n(cs_n), .dq(h_dq), .dq_in(dq_w),
    .oe_n(dut_oe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cmd_stb === 1'b1) stb_n++;
    if (cmd_rej === 1'b1) rej_n++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic setp(input int p);
    proto_dual <= (p == 1);
    proto_quad <= (p == 2);
    tick(2);
  endtask

  task automatic cmd(input logic [7:0] op, input int ln, input int n,
                     input int s, input int r);
    stb_n = 0;
    rej_n = 0;
    host_u.xfer(op, ln, n, rd);
    check(24'(stb_n), 24'(s), "accept pulse");
    check(24'(rej_n), 24'(r), "reject pulse");
    check({16'h0, cmd_code}, {16'h0, op}, "last code");
  endtask

  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    logic [7:0] e [3] = '{8'h00, 8'hC0, 8'h84};
    for (int i = 0; i < 3; i++) begin
      st <= 3'b001 << i;
      tick(3);
      check({16'h0, flag}, {16'h0, e[i]}, "status set");
      st <= 3'b000;
      tick(3);
      check({16'h0, flag}, 24'h80, "status cleared");
    end
  endtask

  task automatic t_errors();
    logic [7:0] e [5] = '{8'hA0, 8'h90, 8'h90, 8'h88, 8'h82};
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h01 << i;
      tick(1);
      ev <= 5'h00;
      tick(8);
      check({16'h0, flag}, {16'h0, e[i]}, "error held");
      cmd(8'h50, 1, 0, 1, 0);
      tick(3);
      check({16'h0, flag}, 24'h80, "error cleared");
    end
  endtask

  // Same flag byte must repeat on every lane width
  task automatic t_read70();
    logic [3:0] oe [3] = '{`FSD_OE_EXT, `FSD_OE_DUAL, `FSD_OE_QUAD};
    ev <= 5'h02;
    st <= 3'b010;
    tick(1);
    ev <= 5'h00;
    for (int p = 0; p < 3; p++) begin
      setp(p);
      cmd(8'h70, 1 << p, 2, 1, 0);
      check({8'h0, rd[15:0]}, 24'hD0D0, "flag read");
      check({20'h0, host_u.oe_min}, {20'h0, oe[p]}, "lanes");
    end
    setp(0);
    st <= 3'b000;
    cmd(8'h50, 1, 0, 1, 0);
  endtask

  task automatic t_proto();
    logic [7:0] op [13] = '{8'hAF, 8'hAF, 8'hAF, 8'h9F, 8'h9F, 8'h3B,
      8'h3B, 8'h6B, 8'h6B, 8'hBB, 8'hEB, 8'h0B, 8'h0B};
    int pr [13] = '{0, 1, 2, 0, 1, 2, 1, 1, 2, 1, 2, 1, 2};
    int ac [13] = '{0, 1, 1, 1, 0, 0, 1, 0, 1, 1, 1, 1, 1};
    for (int i = 0; i < 13; i++) begin
      setp(pr[i]);
      cmd(op[i], 1 << pr[i], 1, ac[i], 1 - ac[i]);
      if (ac[i] == 0)
        check({20'h0, host_u.oe_min}, 24'hF, "silent");
    end
    setp(2);
    cmd(8'hAF, 4, 3, 1, 0);
    check(rd, ID, "id bytes");
    setp(0);
  endtask

  task automatic t_prot();
    ev <= 5'h02;
    tick(1);
    ev <= 5'h00;
    cmd(8'h06, 1, 0, 1, 0);
    cmd(8'h02, 1, 0, 1, 0);
    tick(3);
    check({16'h0, flag}, 24'h92, "protection");
    cmd(8'h50, 1, 0, 1, 0);
    tick(3);
    check({16'h0, flag}, 24'h80, "cleared");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    proto_dual = 1'b0;
    proto_quad = 1'b0;
    st = 3'b000;
    ev = 5'h00;
    fail_count = 0;
    compares = 0;
    tick(16);
    resetn <= 1'b1;
    tick(6);
    check({16'h0, flag}, 24'h80, "reset flags");
    check({20'h0, dut_oe}, 24'hF, "released");
    t_status();
    t_errors();
    t_read70();
    t_proto();
    t_prot();
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
